// >>> hw/pvtm_core.v
// Purpose: ramp generators and status for profile velocity and profile torque modes
// Assumes: single clock pclk, apb slave with zero wait states, ramps update once per millisecond tick
// Notes:   velocities in user units, velocity rates in units per tick, torque slope in units per second, torques in thousandths of rated torque
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "pvtm_map.vh"

module pvtm_core #(
  parameter [31:0] TICK_CYCLES = `PVTM_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        op_enabled,
  input  wire        quick_stop,
  input  wire        closed_loop,
  input  wire [31:0] vel_actual,
  input  wire [31:0] trq_actual,
  output reg  [31:0] vel_demand,
  output reg  [31:0] trq_demand,
  output wire [15:0] statusword
);

  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (32'h00000000 - v) : v;
    end
  endfunction

  function [31:0] umin;
    input [31:0] a;
    input [31:0] b;
    begin
      umin = (a < b) ? a : b;
    end
  endfunction

  // move cur toward goal by at most step, no overshoot
  function [31:0] approach;
    input [31:0] cur;
    input [31:0] goal;
    input [31:0] step;
    reg   [32:0] diff;
    begin
      diff = {goal[31], goal} - {cur[31], cur};
      if (diff[32]) begin
        approach = ((33'h000000000 - diff) > {1'b0, step}) ? (cur - step) : goal;
      end else begin
        approach = (diff > {1'b0, step}) ? (cur + step) : goal;
      end
    end
  endfunction

  // clamp signed value to +-lim
  function [31:0] clamp;
    input [31:0] v;
    input [31:0] lim;
    begin
      if (!v[31] && (v > lim)) begin
        clamp = lim;
      end else if (v[31] && (abs32(v) > lim)) begin
        clamp = 32'h00000000 - lim;
      end else begin
        clamp = v;
      end
    end
  endfunction

  // |a - b| <= win
  function in_window;
    input [31:0] a;
    input [31:0] b;
    input [31:0] win;
    reg   [32:0] d;
    begin
      d = {a[31], a} - {b[31], b};
      in_window = (d[32] ? (33'h000000000 - d) : d) <= {1'b0, win};
    end
  endfunction

  reg  [7:0]  mode_reg;
  reg  [15:0] ctrl_reg;
  reg  [31:0] tgt_vel_reg;
  reg  [31:0] vel_win_reg;
  reg  [15:0] vel_wtime_reg;
  reg  [7:0]  polarity_reg;
  reg  [31:0] accel_reg;
  reg  [31:0] decel_reg;
  reg  [31:0] qs_decel_reg;
  reg  [7:0]  ptype_reg;
  reg  [31:0] jerk_reg;
  reg  [31:0] tgt_trq_reg;
  reg  [31:0] max_trq_reg;
  reg  [31:0] trq_slope_reg;
  reg  [31:0] trq_win_reg;
  reg  [15:0] trq_wtime_reg;
  reg  [31:0] peak_trq_reg;
  reg  [31:0] acc_cur_reg;
  reg  [31:0] tick_cnt_reg;
  reg  [15:0] vel_wcnt_reg;
  reg  [15:0] trq_wcnt_reg;
  reg         vel_reached_reg;
  reg         trq_reached_reg;

  wire        halt      = ctrl_reg[`PVTM_HALT_BIT];
  wire        tick      = (tick_cnt_reg == (TICK_CYCLES - 32'h00000001));
  wire        pv_run    = op_enabled && (mode_reg == `PVTM_MODE_PV);
  wire        pt_run    = op_enabled && (mode_reg == `PVTM_MODE_PT) && closed_loop;

  wire        setup     = psel && !penable;
  wire        access    = psel && penable;
  wire        wr_en     = access && pwrite;

  // address decode, shared by read capture and error answer
  reg         addr_ok;
  reg  [31:0] rd_mux;

  // velocity path
  wire        jerk_mode   = (ptype_reg == `PVTM_PTYPE_JERK);
  reg  [31:0] vel_tgt_pol;
  reg  [31:0] vel_goal;
  reg         vel_away;
  reg  [31:0] vel_rate;
  reg  [31:0] acc_next;
  reg  [31:0] vel_step;

  // goal, rate and step of the velocity ramp for the coming tick
  always @* begin
    if (polarity_reg[`PVTM_POL_VEL_BIT]) begin
      vel_tgt_pol = 32'h00000000 - tgt_vel_reg;
    end else begin
      vel_tgt_pol = tgt_vel_reg;
    end
    if (halt || quick_stop) begin
      vel_goal = 32'h00000000;
    end else begin
      vel_goal = vel_tgt_pol;
    end
    // magnitude growing selects the start ramp, shrinking the brake ramp
    vel_away = (!vel_demand[31] && ($signed(vel_goal) > $signed(vel_demand))) ||
               ((vel_demand[31] || (vel_demand == 32'h00000000)) && ($signed(vel_goal) < $signed(vel_demand)));
    if (quick_stop) begin
      vel_rate = qs_decel_reg;
    end else if (vel_away) begin
      vel_rate = accel_reg;
    end else begin
      vel_rate = decel_reg;
    end
    // acceleration builds up by the jerk limit, drops out at the goal
    if (vel_demand == vel_goal) begin
      acc_next = 32'h00000000;
    end else begin
      acc_next = umin(acc_cur_reg + jerk_reg, vel_rate);
    end
    if (jerk_mode) begin
      vel_step = acc_next;
    end else begin
      vel_step = vel_rate;
    end
  end

  wire        vel_in_win  = in_window(vel_actual, vel_goal, vel_win_reg);

  // torque path
  wire [31:0] trq_lim     = umin(max_trq_reg, peak_trq_reg);
  wire [31:0] trq_step_r  = trq_slope_reg / `PVTM_TICKS_PER_S;
  reg  [31:0] trq_goal;
  reg  [31:0] trq_step;

  // torque goal and per-tick step, the slope being given per second
  always @* begin
    if (halt) begin
      trq_goal = 32'h00000000;
    end else begin
      trq_goal = clamp(tgt_trq_reg, trq_lim);
    end
    // a nonzero slope under one unit per tick still moves one unit per tick
    if ((trq_step_r == 32'h00000000) && (trq_slope_reg != 32'h00000000)) begin
      trq_step = 32'h00000001;
    end else begin
      trq_step = trq_step_r;
    end
  end

  wire [31:0] trq_next    = clamp(approach(trq_demand, trq_goal, trq_step), trq_lim);
  wire        trq_in_win  = in_window(trq_actual, trq_goal, trq_win_reg);
  wire        trq_limit   = (abs32(tgt_trq_reg) > max_trq_reg);

  // bit 10 carries reached/zero depending on halt, decoded by the program with bit 8
  wire        sw_reached  = (mode_reg == `PVTM_MODE_PT) ? trq_reached_reg : vel_reached_reg;
  wire        sw_limit    = (mode_reg == `PVTM_MODE_PT) && trq_limit;
  reg  [15:0] status_bits;

  // only the reached and limit bits are driven, the rest read zero
  always @* begin
    status_bits                    = 16'h0000;
    status_bits[`PVTM_REACHED_BIT] = sw_reached;
    status_bits[`PVTM_LIMIT_BIT]   = sw_limit;
  end

  assign statusword = status_bits;
  assign pready     = 1'b1;
  assign pslverr    = access && !addr_ok;

  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    case (paddr)
      `PVTM_OFF_MODE:      rd_mux = {24'h000000, mode_reg};
      `PVTM_OFF_CTRL:      rd_mux = {16'h0000, ctrl_reg};
      `PVTM_OFF_STATUS:    rd_mux = {16'h0000, statusword};
      `PVTM_OFF_TGT_VEL:   rd_mux = tgt_vel_reg;
      `PVTM_OFF_VEL_WIN:   rd_mux = vel_win_reg;
      `PVTM_OFF_VEL_WTIME: rd_mux = {16'h0000, vel_wtime_reg};
      `PVTM_OFF_POLARITY:  rd_mux = {24'h000000, polarity_reg};
      `PVTM_OFF_ACCEL:     rd_mux = accel_reg;
      `PVTM_OFF_DECEL:     rd_mux = decel_reg;
      `PVTM_OFF_QS_DECEL:  rd_mux = qs_decel_reg;
      `PVTM_OFF_PTYPE:     rd_mux = {24'h000000, ptype_reg};
      `PVTM_OFF_JERK:      rd_mux = jerk_reg;
      `PVTM_OFF_TGT_TRQ:   rd_mux = tgt_trq_reg;
      `PVTM_OFF_MAX_TRQ:   rd_mux = max_trq_reg;
      `PVTM_OFF_TRQ_SLOPE: rd_mux = trq_slope_reg;
      `PVTM_OFF_TRQ_WIN:   rd_mux = trq_win_reg;
      `PVTM_OFF_TRQ_WTIME: rd_mux = {16'h0000, trq_wtime_reg};
      `PVTM_OFF_PEAK_TRQ:  rd_mux = peak_trq_reg;
      `PVTM_OFF_VEL_DEM:   rd_mux = vel_demand;
      `PVTM_OFF_TRQ_DEM:   rd_mux = trq_demand;
      default:             addr_ok = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, valid throughout access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= 8'h00;
      ctrl_reg      <= 16'h0000;
      tgt_vel_reg   <= `PVTM_RST_ZERO;
      vel_win_reg   <= `PVTM_RST_ZERO;
      vel_wtime_reg <= 16'h0000;
      polarity_reg  <= 8'h00;
      accel_reg     <= `PVTM_RST_RATE;
      decel_reg     <= `PVTM_RST_RATE;
      qs_decel_reg  <= `PVTM_RST_RATE;
      ptype_reg     <= `PVTM_PTYPE_TRAP;
      jerk_reg      <= `PVTM_RST_RATE;
      tgt_trq_reg   <= `PVTM_RST_ZERO;
      max_trq_reg   <= `PVTM_RST_MAX_TRQ;
      trq_slope_reg <= `PVTM_RST_ZERO;
      trq_win_reg   <= `PVTM_RST_ZERO;
      trq_wtime_reg <= 16'h0000;
      peak_trq_reg  <= `PVTM_RST_PEAK_TRQ;
    end else if (wr_en) begin
      case (paddr)
        `PVTM_OFF_MODE:      mode_reg      <= pwdata[7:0];
        `PVTM_OFF_CTRL:      ctrl_reg      <= pwdata[15:0];
        `PVTM_OFF_TGT_VEL:   tgt_vel_reg   <= pwdata;
        `PVTM_OFF_VEL_WIN:   vel_win_reg   <= pwdata;
        `PVTM_OFF_VEL_WTIME: vel_wtime_reg <= pwdata[15:0];
        `PVTM_OFF_POLARITY:  polarity_reg  <= pwdata[7:0];
        `PVTM_OFF_ACCEL:     accel_reg     <= pwdata;
        `PVTM_OFF_DECEL:     decel_reg     <= pwdata;
        `PVTM_OFF_QS_DECEL:  qs_decel_reg  <= pwdata;
        `PVTM_OFF_PTYPE:     ptype_reg     <= pwdata[7:0];
        `PVTM_OFF_JERK:      jerk_reg      <= pwdata;
        `PVTM_OFF_TGT_TRQ:   tgt_trq_reg   <= pwdata;
        `PVTM_OFF_MAX_TRQ:   max_trq_reg   <= pwdata;
        `PVTM_OFF_TRQ_SLOPE: trq_slope_reg <= pwdata;
        `PVTM_OFF_TRQ_WIN:   trq_win_reg   <= pwdata;
        `PVTM_OFF_TRQ_WTIME: trq_wtime_reg <= pwdata[15:0];
        `PVTM_OFF_PEAK_TRQ:  peak_trq_reg  <= pwdata;
        default:             ;
      endcase
    end
  end

  // millisecond tick paces both ramps and both window timers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  // velocity ramp generator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_demand  <= 32'h00000000;
      acc_cur_reg <= 32'h00000000;
    end else if (!pv_run) begin
      vel_demand  <= 32'h00000000;
      acc_cur_reg <= 32'h00000000;
    end else if (tick) begin
      acc_cur_reg <= acc_next;
      vel_demand  <= approach(vel_demand, vel_goal, vel_step);
    end
  end

  // velocity window timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_wcnt_reg    <= 16'h0000;
      vel_reached_reg <= 1'b0;
    end else if (!pv_run || !vel_in_win || (vel_demand != vel_goal)) begin
      vel_wcnt_reg    <= 16'h0000;
      vel_reached_reg <= 1'b0;
    end else if (tick) begin
      if (vel_wcnt_reg >= vel_wtime_reg) begin
        vel_reached_reg <= 1'b1;
      end else begin
        vel_wcnt_reg <= vel_wcnt_reg + 16'h0001;
      end
    end
  end

  // torque ramp generator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trq_demand <= 32'h00000000;
    end else if (!pt_run) begin
      trq_demand <= 32'h00000000;
    end else if (tick) begin
      trq_demand <= trq_next;
    end
  end

  // torque window timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trq_wcnt_reg    <= 16'h0000;
      trq_reached_reg <= 1'b0;
    end else if (!pt_run || !trq_in_win || (trq_demand != trq_goal)) begin
      trq_wcnt_reg    <= 16'h0000;
      trq_reached_reg <= 1'b0;
    end else if (tick) begin
      if (trq_wcnt_reg >= trq_wtime_reg) begin
        trq_reached_reg <= 1'b1;
      end else begin
        trq_wcnt_reg <= trq_wcnt_reg + 16'h0001;
      end
    end
  end

endmodule

// >>> hw/pvtm_map.vh
// Purpose: constants for the profile velocity / profile torque mode block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   timing counts are derived from the clock period
`ifndef PVTM_MAP_VH
`define PVTM_MAP_VH

`define PVTM_CLK_NS          32'h00000032
`define PVTM_TICK_NS         32'h000f4240
`define PVTM_TICK_CYCLES     ((`PVTM_TICK_NS + `PVTM_CLK_NS - 32'h00000001) / `PVTM_CLK_NS)
`define PVTM_TICKS_PER_S     32'h000003e8

`define PVTM_OFF_MODE        12'h000
`define PVTM_OFF_CTRL        12'h004
`define PVTM_OFF_STATUS      12'h008
`define PVTM_OFF_TGT_VEL     12'h00c
`define PVTM_OFF_VEL_WIN     12'h010
`define PVTM_OFF_VEL_WTIME   12'h014
`define PVTM_OFF_POLARITY    12'h018
`define PVTM_OFF_ACCEL       12'h01c
`define PVTM_OFF_DECEL       12'h020
`define PVTM_OFF_QS_DECEL    12'h024
`define PVTM_OFF_PTYPE       12'h028
`define PVTM_OFF_JERK        12'h02c
`define PVTM_OFF_TGT_TRQ     12'h030
`define PVTM_OFF_MAX_TRQ     12'h034
`define PVTM_OFF_TRQ_SLOPE   12'h038
`define PVTM_OFF_TRQ_WIN     12'h03c
`define PVTM_OFF_TRQ_WTIME   12'h040
`define PVTM_OFF_PEAK_TRQ    12'h044
`define PVTM_OFF_VEL_DEM     12'h048
`define PVTM_OFF_TRQ_DEM     12'h04c

`define PVTM_MODE_PV         8'h03
`define PVTM_MODE_PT         8'h04
`define PVTM_PTYPE_TRAP      8'h00
`define PVTM_PTYPE_JERK      8'h03
`define PVTM_HALT_BIT        8
`define PVTM_REACHED_BIT     10
`define PVTM_LIMIT_BIT       11
`define PVTM_POL_VEL_BIT     6

`define PVTM_RST_ZERO        32'h00000000
`define PVTM_RST_MAX_TRQ     32'h000003e8
`define PVTM_RST_PEAK_TRQ    32'h000003e8
`define PVTM_RST_RATE        32'h00000001

`endif

// >>> dv/pvtm_chk_asserts.sv
// Purpose: port-level checks for the mode ramp block
// Assumes: halt seen by snooping apb writes to the control word
// Notes:   tick phase rebuilt from reset release
`timescale 1ns/1ns
module pvtm_chk #(
  parameter [31:0] TICK_CYCLES = 32'h00004e20
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        op_enabled,
  input wire        quick_stop,
  input wire        closed_loop,
  input wire [31:0] vel_actual,
  input wire [31:0] trq_actual,
  input wire [31:0] vel_demand,
  input wire [31:0] trq_demand,
  input wire [15:0] statusword
);
  localparam int PEAK = 1000;
  reg  [31:0] cyc_reg;
  reg  [31:0] open_reg;
  reg  [31:0] dis_reg;
  reg         halt_reg;
  wire        tick_now = (cyc_reg == TICK_CYCLES - 32'd1);
  wire        wr_now   = psel & penable & pwrite;
  wire        stop_now = halt_reg | quick_stop;
  function automatic [31:0] mag(input [31:0] v);
    mag = v[31] ? -v : v;
  endfunction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= 32'h0;
      open_reg <= 32'h0;
      dis_reg <= 32'h0;
      halt_reg <= 1'b0;
    end else begin
      cyc_reg <= tick_now ? 32'h0 : cyc_reg + 32'h1;
      open_reg <= closed_loop ? 32'h0 : open_reg + 32'h1;
      dis_reg <= op_enabled ? 32'h0 : dis_reg + 32'h1;
      if (wr_now && paddr == 12'h004)
        halt_reg <= pwdata[8];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_vel_tick; $changed(vel_demand) |-> $past(tick_now) || vel_demand == 32'h0; endproperty
  a_vel_tick: assert property (p_vel_tick) else $error("velocity demand moved off tick");
  property p_trq_tick; $changed(trq_demand) |-> $past(tick_now) || trq_demand == 32'h0; endproperty
  a_trq_tick: assert property (p_trq_tick) else $error("torque demand moved off tick");
  property p_peak; $signed(trq_demand) <= PEAK && $signed(trq_demand) >= -PEAK; endproperty
  a_peak: assert property (p_peak) else $error("torque demand beyond limit");
  property p_open; open_reg > TICK_CYCLES |-> trq_demand == 32'h0; endproperty
  a_open: assert property (p_open) else $error("torque driven in open loop");
  property p_dis; dis_reg > TICK_CYCLES |-> vel_demand == 32'h0; endproperty
  a_dis: assert property (p_dis) else $error("velocity driven while disabled");
  property p_stop; stop_now && $past(stop_now) |-> mag(vel_demand) <= mag($past(vel_demand)); endproperty
  a_stop: assert property (p_stop) else $error("speed grew while stopping");
  property p_flag; $rose(statusword[10]) |-> $past(tick_now) || $past(wr_now); endproperty
  a_flag: assert property (p_flag) else $error("reached flag set off tick");
  property p_bits; statusword[15:12] == 4'h0 && statusword[9:0] == 10'h0; endproperty
  a_bits: assert property (p_bits) else $error("unused status bits set");
  c_reach: cover property ($rose(statusword[10]));
  c_limit: cover property ($rose(statusword[11]));
  c_qs: cover property ($rose(quick_stop));
endmodule
bind pvtm_core pvtm_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_enabled(op_enabled),
  .quick_stop(quick_stop), .closed_loop(closed_loop), .vel_actual(vel_actual), .trq_actual(trq_actual),
  .vel_demand(vel_demand), .trq_demand(trq_demand), .statusword(statusword));

// >>> dv/pvtm_prog.sv
// Purpose: controlling program model, apb master
// Assumes: one transfer at a time
// Notes:   write data inverted when idle
`timescale 1ns/1ns
module pvtm_prog (
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
    end
  endtask
endmodule

// >>> dv/tb_pvtm_core.sv
// Purpose: self-checking bench for the mode ramp block
// Assumes: short tick of four clocks
// Notes:   program model drives apb
`timescale 1ns/1ns
`include "pvtm_map.vh"
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, sn); end end
module tb_pvtm_core;
  localparam [31:0] TK = 32'd4;
  reg         pclk, presetn, op_enabled, quick_stop, closed_loop, e;
  reg  [31:0] vel_actual, trq_actual, q;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata, vel_demand, trq_demand;
  wire [15:0] statusword;
  integer     err_count, total_checks;
  pvtm_core #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_enabled(op_enabled), .quick_stop(quick_stop), .closed_loop(closed_loop), .vel_actual(vel_actual),
    .trq_actual(trq_actual), .vel_demand(vel_demand), .trq_demand(trq_demand), .statusword(statusword));
  pvtm_prog u_prog (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task wr(input [11:0] a, input [31:0] d);
    u_prog.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input [11:0] a);
    u_prog.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // c=1 waits for a change away from v, c=0 waits for v
  task wt(input t, input c, input [31:0] v);
    integer i;
    for (i = 0; i < 3000 && (((t ? trq_demand : vel_demand) === v) == c); i++)
      @(posedge pclk);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task s_regs;
    begin
      rd(`PVTM_OFF_MAX_TRQ);
      `CHK("max_trq", `PVTM_RST_MAX_TRQ, q)
      rd(`PVTM_OFF_PEAK_TRQ);
      `CHK("peak_trq", `PVTM_RST_PEAK_TRQ, q)
      rd(12'h0fc);
      `CHK("unmapped", 33'h100000000, {e, q})
    end
  endtask
  task s_vel;
    begin
      wr(`PVTM_OFF_ACCEL, 32'h5);
      wr(`PVTM_OFF_DECEL, 32'h2);
      wr(`PVTM_OFF_QS_DECEL, 32'ha);
      wr(`PVTM_OFF_VEL_WIN, 32'h1);
      wr(`PVTM_OFF_VEL_WTIME, 32'h2);
      wr(`PVTM_OFF_TGT_VEL, 32'h14);
      vel_actual <= 32'h14;
      wr(`PVTM_OFF_MODE, 32'h3);
      wt(0, 1, 32'h0);
      `CHK("accel_step", 32'h5, vel_demand)
      wt(0, 0, 32'h14);
      `CHK("flag_early", 1'b0, statusword[10])
      rd(`PVTM_OFF_VEL_DEM);
      `CHK("vel_dem_reg", 32'h14, q)
      repeat (16) @(posedge pclk);
      `CHK("in_window", 1'b1, statusword[10])
      vel_actual <= 32'h17;
      repeat (3) @(posedge pclk);
      `CHK("out_window", 1'b0, statusword[10])
      wr(`PVTM_OFF_POLARITY, 32'h40);
      wt(0, 1, 32'h14);
      `CHK("decel_step", 32'h12, vel_demand)
      wt(0, 0, -32'h14);
      `CHK("negated", -32'h14, vel_demand)
      vel_actual <= 32'h0;
      wr(`PVTM_OFF_CTRL, 32'h100);
      wt(0, 0, 32'h0);
      repeat (16) @(posedge pclk);
      `CHK("halt_zero", 1'b1, statusword[10])
      wr(`PVTM_OFF_CTRL, 32'h0);
      wt(0, 0, -32'h14);
      quick_stop <= 1'b1;
      wt(0, 1, -32'h14);
      `CHK("qs_step", -32'ha, vel_demand)
      wt(0, 0, 32'h0);
      wr(`PVTM_OFF_PTYPE, 32'h3);
      wr(`PVTM_OFF_JERK, 32'h1);
      quick_stop <= 1'b0;
      wt(0, 1, 32'h0);
      `CHK("jerk_soft", 1'b1, $signed(vel_demand) > -5)
      wt(0, 0, -32'h14);
      `CHK("jerk_end", -32'h14, vel_demand)
      op_enabled <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK("disabled", 32'h0, vel_demand)
    end
  endtask
  task s_trq;
    begin
      op_enabled <= 1'b1;
      trq_actual <= 32'h3e8;
      wr(`PVTM_OFF_TRQ_SLOPE, 32'hbb8);
      wr(`PVTM_OFF_TRQ_WIN, 32'h5);
      wr(`PVTM_OFF_TRQ_WTIME, 32'h1);
      wr(`PVTM_OFF_TGT_TRQ, 32'h7d0);
      wr(`PVTM_OFF_MODE, 32'h4);
      @(posedge pclk);
      `CHK("limit_bit", 1'b1, statusword[11])
      wt(1, 1, 32'h0);
      `CHK("slope_step", 32'h3, trq_demand)
      wt(1, 0, 32'h3e8);
      `CHK("max_clamp", 32'h3e8, trq_demand)
      repeat (16) @(posedge pclk);
      `CHK("trq_reached", 1'b1, statusword[10])
      wr(`PVTM_OFF_TGT_TRQ, 32'h1f4);
      @(posedge pclk);
      `CHK("limit_clear", 1'b0, statusword[11])
      closed_loop <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK("open_loop", 32'h0, trq_demand)
      closed_loop <= 1'b1;
      trq_actual <= 32'h0;
      wr(`PVTM_OFF_CTRL, 32'h100);
      repeat (20) @(posedge pclk);
      `CHK("trq_halt", 33'h100000000, {statusword[10], trq_demand})
      wr(`PVTM_OFF_PEAK_TRQ, 32'h258);
      wr(`PVTM_OFF_TGT_TRQ, 32'h7d0);
      wr(`PVTM_OFF_CTRL, 32'h0);
      wt(1, 1, 32'h0);
      `CHK("halt_start", 32'h3, trq_demand)
      wt(1, 0, 32'h258);
      `CHK("peak_clamp", 32'h258, trq_demand)
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(50 * 60000);
    err_count++;
    print_verdict;
  end
  initial begin
    err_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    op_enabled = 1'b1;
    quick_stop = 1'b0;
    closed_loop = 1'b1;
    vel_actual = 32'h0;
    trq_actual = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs;
    s_vel;
    s_trq;
    print_verdict;
  end
endmodule
